// >>> design/epiu_core.sv
`timescale 1ns/1ps
`include "epiu_defs.svh"

module epiu_core #(
  parameter int STARTUP_CYC = `EPIU_STARTUP_CYC,
  parameter int WDT_CYC     = `EPIU_WDT_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [9:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt pins
  input  wire logic [7:0]        ext_line_pins,
  // Core side
  input  wire logic              global_irq_en,
  input  wire logic [7:0]        irq_ack,
  input  wire logic              deep_sleep,
  input  wire logic              legacy_mode,
  output epiu_pkg::epiu_irq_t    irq,
  output logic                   wake_pulse
);

  // ==========================================================
  // Registers and shared signals
  logic [7:0]            flags_q;
  logic [7:0]            mask_q;
  logic [7:0]            sen_hi_q;
  logic [7:0]            sen_lo_q;
  epiu_pkg::epiu_state_t state_q;
  logic [7:0]            wd_cnt_q;
  logic [15:0]           st_cnt_q;
  logic [1:0]            smp_n_q;
  logic                  wake_q;
  logic                  deep_q;
  logic [31:0]           prdata_q;
  logic                  err_q;
  logic [15:0]           sense_all;
  logic [7:0]            pin_eff;
  logic [7:0]            lvl_mode;
  logic [7:0]            lvl_low;
  logic [7:0]            evt;
  logic [7:0]            w1c;
  logic [7:0]            pend;
  logic                  run;
  logic                  wd_tick;
  logic                  setup;
  logic                  wr;

  assign run = (state_q == epiu_pkg::ST_RUN);
  assign sense_all = {sen_hi_q, legacy_mode ? 8'h00 : sen_lo_q};

  // Disabled lines 0-3 lose their input buffer in deep sleep
  assign pin_eff = ext_line_pins &
                   ~{4'h0, ~mask_q[3:0] & {4{~run}}};

  // ==========================================================
  // Per-line detection
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_line
      logic [1:0] sm;
      assign sm = sense_all[2*i +: 2];
      assign lvl_mode[i] = (sm == epiu_pkg::SENSE_LOW);
      assign lvl_low[i] = lvl_mode[i] & ~pin_eff[i] & mask_q[i];
      if (i < 4)
      begin : g_async
        logic edge_clk;
        logic tgl_q;
        logic s1_q;
        logic s2_q;
        logic s3_q;
        // Fall selects the inverted pin so both edges are rising
        assign edge_clk = pin_eff[i] ^ ~sm[0];
        always_ff @(posedge edge_clk or negedge resetn)
        begin
          if (!resetn)
            tgl_q <= 1'b0;
          else
            tgl_q <= ~tgl_q;
        end
        always_ff @(posedge clk or negedge resetn)
        begin
          if (!resetn)
          begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
          end
          else
          begin
            s1_q <= tgl_q;
            s2_q <= s1_q;
            s3_q <= s2_q;
          end
        end
        // Any-edge code 01 (SENSE_ANY) never raises an edge event on lines 0-3
        assign evt[i] = (s2_q ^ s3_q) & sm[1];
      end
      else
      begin : g_sync
        logic smp_q;
        logic prv_q;
        // Sampling only runs while the I/O clock would run
        always_ff @(posedge clk or negedge resetn)
        begin
          if (!resetn)
          begin
            smp_q <= 1'b0;
            prv_q <= 1'b0;
          end
          else if (run)
          begin
            smp_q <= pin_eff[i];
            prv_q <= smp_q;
          end
        end
        always_comb
        begin
          unique case (sm)
            epiu_pkg::SENSE_ANY:  evt[i] = run & (smp_q ^ prv_q);
            epiu_pkg::SENSE_FALL: evt[i] = run & prv_q & ~smp_q;
            epiu_pkg::SENSE_RISE: evt[i] = run & ~prv_q & smp_q;
            epiu_pkg::SENSE_LOW:  evt[i] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================
  // APB access
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & err_q;

  function automatic logic hit(input logic [9:0] a,
                               input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q <= 32'h0;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      err_q <= 1'b0;
      prdata_q <= 32'h0;
      if (hit(paddr, `EPIU_IDX_FLAGS))
        prdata_q <= {24'h0, flags_q};
      else if (hit(paddr, `EPIU_IDX_MASK))
        prdata_q <= {24'h0, mask_q};
      else if (hit(paddr, `EPIU_IDX_SEN_HI))
        prdata_q <= {24'h0, sen_hi_q};
      else if (hit(paddr, `EPIU_IDX_SEN_LO) && !legacy_mode)
        prdata_q <= {24'h0, sen_lo_q};
      else if (hit(paddr, `EPIU_IDX_STATUS))
      begin
        prdata_q[`EPIU_ST_PINS_LSB +: 8] <= pin_eff;
        prdata_q[`EPIU_ST_FSM_LSB +: 2] <= state_q;
      end
      else
        err_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mask_q <= `EPIU_RST_BYTE;
      sen_hi_q <= `EPIU_RST_BYTE;
      sen_lo_q <= `EPIU_RST_BYTE;
    end
    else if (wr)
    begin
      if (hit(paddr, `EPIU_IDX_MASK))
        mask_q <= pwdata[7:0];
      if (hit(paddr, `EPIU_IDX_SEN_HI))
        sen_hi_q <= pwdata[7:0];
      if (hit(paddr, `EPIU_IDX_SEN_LO) && !legacy_mode)
        sen_lo_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Flags
  assign w1c = (wr && hit(paddr, `EPIU_IDX_FLAGS)) ?
               pwdata[7:0] : 8'h00;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flags_q <= `EPIU_RST_BYTE;
    else
      flags_q <= ((flags_q & ~(w1c | irq_ack)) | evt) &
                 ~lvl_mode;
  end

  // ==========================================================
  // Request and vector
  assign pend = (flags_q | (lvl_low & {8{run}})) & mask_q;

  always_comb
  begin
    irq.req = global_irq_en & (|pend);
    irq.vec = 3'h0;
    for (int n = 7; n >= 0; n--)
      if (pend[n])
        irq.vec = 3'(n);
  end

  // ==========================================================
  // Sleep and wake sequencing
  assign wd_tick = (wd_cnt_q == 8'(WDT_CYC - 1));
  assign wake_pulse = wake_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      deep_q <= 1'b0;
    else
      deep_q <= deep_sleep;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wd_cnt_q <= 8'h0;
    else if (state_q != epiu_pkg::ST_CHECK || wd_tick)
      wd_cnt_q <= 8'h0;
    else
      wd_cnt_q <= wd_cnt_q + 8'h1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= epiu_pkg::ST_RUN;
      st_cnt_q <= 16'h0;
      smp_n_q <= 2'h0;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= 1'b0;
      unique case (state_q)
        epiu_pkg::ST_RUN:
          if (deep_sleep && !deep_q)
            state_q <= epiu_pkg::ST_SLEEP;
        epiu_pkg::ST_SLEEP:
        begin
          smp_n_q <= 2'h0;
          st_cnt_q <= 16'h0;
          if (|(evt[3:0] & mask_q[3:0]))
            state_q <= epiu_pkg::ST_STARTUP;
          else if (|lvl_low)
            state_q <= epiu_pkg::ST_CHECK;
        end
        epiu_pkg::ST_CHECK:
          if (wd_tick)
          begin
            if (!(|lvl_low))
              state_q <= epiu_pkg::ST_SLEEP;
            else if (smp_n_q == 2'(`EPIU_WDT_SAMPLES - 1))
              state_q <= epiu_pkg::ST_STARTUP;
            else
              smp_n_q <= smp_n_q + 2'h1;
          end
        epiu_pkg::ST_STARTUP:
          if (st_cnt_q == 16'(STARTUP_CYC - 1))
          begin
            state_q <= epiu_pkg::ST_RUN;
            wake_q <= 1'b1;
          end
          else
            st_cnt_q <= st_cnt_q + 16'h1;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_w1c;
    wr && hit(paddr, `EPIU_IDX_FLAGS) |=>
      ((flags_q & $past(pwdata[7:0] & ~evt)) == 8'h0);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by writing one");

  property p_keep;
    wr && hit(paddr, `EPIU_IDX_FLAGS) && (irq_ack == 8'h0) |=>
      ((flags_q & ~$past(pwdata[7:0])) == (($past(flags_q) | $past(evt)) &
       ~$past(pwdata[7:0]) & ~$past(lvl_mode)));
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag written zero changed");

  property p_lvl_flag;
    (flags_q & $past(lvl_mode)) == 8'h0;
  endproperty
  a_lvl_flag: assert property (p_lvl_flag)
    else $error("level line shows a flag");

  property p_lvl_req;
    run && global_irq_en && (|lvl_low) |-> irq.req;
  endproperty
  a_lvl_req: assert property (p_lvl_req)
    else $error("held low level gave no request");

  property p_gate;
    irq.req |-> global_irq_en && (|mask_q) && pend[irq.vec];
  endproperty
  a_gate: assert property (p_gate)
    else $error("request without enable or mask");

  property p_rise5;
    run && sense_all[11:10] == epiu_pkg::SENSE_RISE &&
      !pin_eff[5] ##1 run && pin_eff[5] ##1 run && irq_ack == 8'h0
      |=> ##1 flags_q[5] || $past(w1c[5] | irq_ack[5]);
  endproperty
  a_rise5: assert property (p_rise5)
    else $error("sampled rise on line 5 missed");

  property p_noio;
    !run && $past(!run) |-> !$rose(flags_q[4]);
  endproperty
  a_noio: assert property (p_noio)
    else $error("clocked edge flag set in sleep");

  property p_twice;
    state_q == epiu_pkg::ST_CHECK ##1
      state_q == epiu_pkg::ST_STARTUP |-> $past(smp_n_q) == 2'h1;
  endproperty
  a_twice: assert property (p_twice)
    else $error("wake after fewer than two samples");

  property p_startup;
    state_q == epiu_pkg::ST_STARTUP &&
      st_cnt_q == 16'(STARTUP_CYC - 1) |=> run && wake_pulse;
  endproperty
  a_startup: assert property (p_startup)
    else $error("startup end did not wake");

  property p_legacy;
    setup && legacy_mode && hit(paddr, `EPIU_IDX_SEN_LO) |=>
      prdata == 32'h0 && pslverr;
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("low sense reachable in legacy mode");

  c_wake: cover property (state_q == epiu_pkg::ST_STARTUP ##1 run);
  c_edge: cover property ($rose(flags_q[0]) && mask_q[0]);
  c_any: cover property (run && $rose(flags_q[4]));

endmodule : epiu_core

// >>> design/epiu_defs.svh
`ifndef EPIU_DEFS_SVH
`define EPIU_DEFS_SVH

// Register word indexes; byte address is four times the index
`define EPIU_IDX_FLAGS   8'h38
`define EPIU_IDX_MASK    8'h39
`define EPIU_IDX_SEN_HI  8'h3a
`define EPIU_IDX_SEN_LO  8'h3b
`define EPIU_IDX_STATUS  8'h3c

`define EPIU_RST_BYTE    8'h00

// Status word fields
`define EPIU_ST_PINS_LSB 0
`define EPIU_ST_FSM_LSB  8

// Timing
`define EPIU_CLK_NS      25
`define EPIU_WDT_NS      1000
`define EPIU_WDT_CYC     ((`EPIU_WDT_NS + `EPIU_CLK_NS - 1) / `EPIU_CLK_NS)
`define EPIU_WDT_SAMPLES 2
`define EPIU_STARTUP_CYC 64

`endif

// >>> design/epiu_pkg.sv
package epiu_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_ANY  = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } epiu_sense_t;

  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_SLEEP   = 2'h1,
    ST_CHECK   = 2'h3,
    ST_STARTUP = 2'h2
  } epiu_state_t;

  typedef struct packed {
    logic       req;
    logic [2:0] vec;
  } epiu_irq_t;

endpackage : epiu_pkg

// >>> verif/epiu_pin_src.sv
`timescale 1ns/1ps
// ==========================================
// External source driving the interrupt pins
module epiu_pin_src (
  // Clock
  input  wire logic       clk,
  // Level asked for by the bench
  input  wire logic [7:0] level_req,
  // Pins
  output logic      [7:0] ext_line_pins
);
  initial ext_line_pins = 8'hff;

  // A level is held until the bench asks for another one
  always @(posedge clk)
  begin
    ext_line_pins <= level_req;
  end
endmodule : epiu_pin_src

// >>> verif/tb_external_pin_interrupt_unit.sv
`timescale 1ns/1ps
`include "epiu_defs.svh"
module tb_external_pin_interrupt_unit;
  logic                clk, resetn, psel, penable, pwrite, pready;
  logic                pslverr, global_irq_en, legacy_mode, wake_pulse;
  logic                probe, woke, deep_sleep;
  logic [9:0]          paddr;
  logic [31:0]         pwdata, prdata, seed;
  logic [7:0]          irq_ack, pins_req, ext_line_pins;
  logic [8:0]          er;
  logic [4:0]          ei;
  logic [8:0]          exp_rd[$];
  logic [4:0]          exp_irq[$];
  epiu_pkg::epiu_irq_t irq;
  int                  errors, checked;

  epiu_core #(.STARTUP_CYC(4), .WDT_CYC(4)) dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_line_pins(ext_line_pins), .global_irq_en(global_irq_en),
    .irq_ack(irq_ack), .deep_sleep(deep_sleep), .legacy_mode(legacy_mode),
    .irq(irq), .wake_pulse(wake_pulse));

  epiu_pin_src src (.clk(clk), .level_req(pins_req),
    .ext_line_pins(ext_line_pins));

  // ==========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] idx, input logic [8:0] e);
    exp_rd.push_back(e);
    apb(1'b0, idx, 8'h00);
  endtask : rd

  task automatic probe_irq(input logic [4:0] e);
    exp_irq.push_back(e);
    @(posedge clk);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask : probe_irq

  task automatic end_sim;
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // ==========
  // Result monitor
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0)
    begin
      er = exp_rd.pop_front();
      checked++;
      if ({pslverr, prdata} !== {er[8], 24'h0, er[7:0]})
      begin
        errors++;
        $display("[FAIL] %0t got %h exp %h", $time, {pslverr, prdata}, er);
      end
    end
    if (probe && exp_irq.size() > 0)
    begin
      ei = exp_irq.pop_front();
      checked++;
      if ({woke, irq.req} !== ei[4:3] || (ei[3] && irq.vec !== ei[2:0]))
      begin
        errors++;
        $display("[FAIL] %0t got %h exp %h", $time, {woke, irq}, ei);
      end
      woke = 1'b0;
    end
    if (wake_pulse)
      woke = 1'b1;
  end

  // ==========
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #500000;
    errors++;
    end_sim();
  end

  // ==========
  // Stimulus
  initial
  begin
    {resetn, psel, penable, pwrite, probe, woke} = '0;
    {global_irq_en, legacy_mode, paddr, pwdata, irq_ack, deep_sleep} = '0;
    pins_req = 8'hff;
    seed = 32'h2145bc0e;
    errors = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(`EPIU_IDX_FLAGS, 9'h000);
    rd(`EPIU_IDX_MASK, 9'h000);
    rd(`EPIU_IDX_SEN_HI, 9'h000);
    rd(`EPIU_IDX_SEN_LO, 9'h000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      apb(1'b1, `EPIU_IDX_MASK, seed[7:0]);
      rd(`EPIU_IDX_MASK, {1'b0, seed[7:0]});
    end
    apb(1'b1, `EPIU_IDX_MASK, 8'h00);
    pins_req <= 8'hf7;
    apb(1'b1, `EPIU_IDX_SEN_LO, 8'hc9);
    repeat (6) @(posedge clk);
    apb(1'b1, `EPIU_IDX_FLAGS, 8'hff);
    pins_req <= 8'hfc;
    repeat (6) @(posedge clk);
    rd(`EPIU_IDX_FLAGS, 9'h00a);
    apb(1'b1, `EPIU_IDX_MASK, 8'h02);
    global_irq_en <= 1'b1;
    probe_irq(5'h09);
    global_irq_en <= 1'b0;
    probe_irq(5'h00);
    irq_ack <= 8'h02;
    @(posedge clk);
    irq_ack <= 8'h00;
    rd(`EPIU_IDX_FLAGS, 9'h008);
    pins_req <= 8'hdc;
    apb(1'b1, `EPIU_IDX_SEN_HI, 8'h0d);
    repeat (6) @(posedge clk);
    apb(1'b1, `EPIU_IDX_FLAGS, 8'hff);
    pins_req <= 8'hec;
    repeat (6) @(posedge clk);
    rd(`EPIU_IDX_FLAGS, 9'h030);
    apb(1'b1, `EPIU_IDX_FLAGS, 8'h00);
    rd(`EPIU_IDX_FLAGS, 9'h030);
    apb(1'b1, `EPIU_IDX_FLAGS, 8'h10);
    rd(`EPIU_IDX_FLAGS, 9'h020);
    apb(1'b1, `EPIU_IDX_MASK, 8'h04);
    global_irq_en <= 1'b1;
    pins_req <= 8'he8;
    repeat (4) @(posedge clk);
    probe_irq(5'h0a);
    rd(`EPIU_IDX_FLAGS, 9'h020);
    pins_req <= 8'hec;
    repeat (4) @(posedge clk);
    probe_irq(5'h00);
    deep_sleep <= 1'b1;
    pins_req <= 8'he8;
    repeat (20) @(posedge clk);
    probe_irq(5'h1a);
    rd(`EPIU_IDX_FLAGS, 9'h028);
    deep_sleep <= 1'b0;
    pins_req <= 8'hec;
    @(posedge clk);
    deep_sleep <= 1'b1;
    pins_req <= 8'he8;
    repeat (11) @(posedge clk);
    pins_req <= 8'hec;
    repeat (10) @(posedge clk);
    probe_irq(5'h10);
    legacy_mode <= 1'b1;
    rd(`EPIU_IDX_SEN_LO, 9'h100);
    rd(8'h3d, 9'h100);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : tb_external_pin_interrupt_unit
